// ### mdu_pkg.sv
// shared types and constants of the multiply/divide unit
package muldiv_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SLICE_W   = 16;
  localparam int unsigned CNT_W     = 6;

  localparam logic [CNT_W-1:0] DIV_STEPS   = 6'h20;
  localparam logic [CNT_W-1:0] SKIP_BYTE   = 6'h17;
  localparam logic [CNT_W-1:0] SKIP_HALF   = 6'h0F;
  localparam logic [CNT_W-1:0] SKIP_TRIPLE = 6'h07;

  localparam logic [63:0]         HILO_RESET = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0]   WORD_ZERO  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]    CNT_ZERO   = 6'h00;

  typedef enum logic [2:0] {
    OP_MULT,
    OP_MULTU,
    OP_MADD,
    OP_MADDU,
    OP_DIV,
    OP_DIVU
  } muldiv_op_e;

  typedef struct packed {
    muldiv_op_e        op;
    logic [DATA_W-1:0] first_source_operand;
    logic [DATA_W-1:0] second_source_operand;
  } issue_s;

  typedef struct packed {
    logic [DATA_W-1:0] result_high_reg;
    logic [DATA_W-1:0] result_low_reg;
  } result_s;

  typedef enum logic [1:0] {
    S_IDLE,
    S_DIV,
    S_FIX
  } div_state_e;

endpackage : muldiv_pkg

// ### mult_div_unit.sv
// multiply/divide unit with its own pipeline, high/low result pair and divider
//
// How it works
// - own pipeline runs beside integer pipeline, never stalls with it.
// - multiplier is a recoded 32 by 16 slice array per pass.
// - pass count chosen from second source operand only.
// - second operand fitting 16 bits takes one pass, otherwise two.
// - short multiply accepted each cycle; full multiply every other cycle.
// - back-to-back full multiplies interlocked until second pass is done.
// - results held in high/low pair; divide sequenced by its own machine.
// - division makes one quotient bit per clock.
// - dividend sign extension skips 23, 15 or 7 iterations.
// - any issue during an active divide stalls until divide completes.
`timescale 1ns/100ps

module mult_div_unit (
  input  wire logic            clock,
  input  wire logic            resetn,
  input  wire logic            issue_valid,
  input  muldiv_pkg::issue_s   issue,
  output muldiv_pkg::result_s  result,
  output logic                 issue_stall,
  output logic                 divide_done
);

  logic [63:0]               hilo_q, hilo_d;
  logic                      stall_q, stall_d;
  logic                      done_q, done_d;

  // issue decode
  logic                      accept;
  logic                      is_mul;
  logic                      is_div;
  logic                      op_signed;
  logic                      op_acc;
  logic                      opb_short;
  logic                      mul_long;
  logic [31:0]               opa;
  logic [31:0]               opb;

  assign opa       = issue.first_source_operand;
  assign opb       = issue.second_source_operand;
  // no stall input from the integer pipeline: work in flight always advances
  assign accept    = issue_valid && !stall_q;
  assign is_mul    = (issue.op == muldiv_pkg::OP_MULT) || (issue.op == muldiv_pkg::OP_MULTU)
                  || (issue.op == muldiv_pkg::OP_MADD) || (issue.op == muldiv_pkg::OP_MADDU);
  assign is_div    = (issue.op == muldiv_pkg::OP_DIV) || (issue.op == muldiv_pkg::OP_DIVU);
  assign op_signed = (issue.op == muldiv_pkg::OP_MULT) || (issue.op == muldiv_pkg::OP_MADD)
                  || (issue.op == muldiv_pkg::OP_DIV);
  assign op_acc    = (issue.op == muldiv_pkg::OP_MADD) || (issue.op == muldiv_pkg::OP_MADDU);
  // only the second operand is looked at to size the multiply
  assign opb_short = op_signed ? (opb[31:15] == {17{opb[15]}})
                               : (opb[31:16] == 16'h0000);
  assign mul_long  = accept && is_mul && !opb_short;

  // multiply pipeline: pass stage then write stage
  logic                      pass2_q, pass2_d;
  logic [31:0]               m_opa_q, m_opa_d;
  logic [15:0]               m_opbh_q, m_opbh_d;
  logic                      m_sgn_q, m_sgn_d;
  logic                      m_acc_q, m_acc_d;
  logic                      pv_q, pv_d;
  logic                      pacc_q, pacc_d;
  logic [63:0]               pprod_q, pprod_d;

  logic [32:0]               mul_a;
  logic [16:0]               mul_b;
  logic [49:0]               mul_p;

  always_comb
  begin
    pass2_d  = 1'b0;
    m_opa_d  = m_opa_q;
    m_opbh_d = m_opbh_q;
    m_sgn_d  = m_sgn_q;
    m_acc_d  = m_acc_q;
    pv_d     = 1'b0;
    pacc_d   = pacc_q;
    mul_a    = 33'h0_0000_0000;
    mul_b    = 17'h0_0000;
    if (pass2_q)
    begin
      // upper slice of a full multiply, always added on top of the lower one
      mul_a  = {m_sgn_q & m_opa_q[31], m_opa_q};
      mul_b  = {m_sgn_q & m_opbh_q[15], m_opbh_q};
      pv_d   = 1'b1;
      pacc_d = 1'b1;
    end
    else if (accept && is_mul)
    begin
      mul_a    = {op_signed & opa[31], opa};
      mul_b    = opb_short ? {op_signed & opb[15], opb[15:0]} : {1'b0, opb[15:0]};
      pv_d     = 1'b1;
      pacc_d   = op_acc;
      pass2_d  = mul_long;
      m_opa_d  = opa;
      m_opbh_d = opb[31:16];
      m_sgn_d  = op_signed;
      m_acc_d  = op_acc;
    end
    // operands widened first so no tool can size the product at 33 bits
    mul_p   = 50'($signed({{17{mul_a[32]}}, mul_a}) * $signed({{33{mul_b[16]}}, mul_b}));
    pprod_d = pass2_q ? {mul_p[47:0], 16'h0000} : {{14{mul_p[49]}}, mul_p};
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pass2_q  <= 1'b0;
      m_opa_q  <= muldiv_pkg::WORD_ZERO;
      m_opbh_q <= 16'h0000;
      m_sgn_q  <= 1'b0;
      m_acc_q  <= 1'b0;
      pv_q     <= 1'b0;
      pacc_q   <= 1'b0;
      pprod_q  <= muldiv_pkg::HILO_RESET;
    end
    else
    begin
      pass2_q  <= pass2_d;
      m_opa_q  <= m_opa_d;
      m_opbh_q <= m_opbh_d;
      m_sgn_q <= m_sgn_d;
      m_acc_q <= m_acc_d;
      pv_q    <= pv_d;
      pacc_q  <= pacc_d;
      pprod_q <= pprod_d;
    end
  end

  // divider
  muldiv_pkg::div_state_e    st_q, st_d;
  logic [5:0]                cnt_q, cnt_d;
  logic [31:0]               quo_q, quo_d;
  logic [31:0]               rem_q, rem_d;
  logic [31:0]               dvs_q, dvs_d;
  logic                      qneg_q, qneg_d;
  logic                      rneg_q, rneg_d;

  logic [31:0]               mag_a;
  logic [31:0]               mag_b;
  logic [5:0]                skip;
  logic [32:0]               shifted;
  logic [33:0]               trial;

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    quo_d   = quo_q;
    rem_d   = rem_q;
    dvs_d   = dvs_q;
    qneg_d  = qneg_q;
    rneg_d  = rneg_q;
    done_d  = 1'b0;
    mag_a   = (op_signed && opa[31]) ? 32'(-opa) : opa;
    mag_b   = (op_signed && opb[31]) ? 32'(-opb) : opb;
    // early-in: narrow dividends start further down the bit ladder
    if (op_signed ? (opa[31:7] == {25{opa[7]}}) : (opa[31:8] == 24'h00_0000))
      skip = muldiv_pkg::SKIP_BYTE;
    else if (op_signed ? (opa[31:15] == {17{opa[15]}}) : (opa[31:16] == 16'h0000))
      skip = muldiv_pkg::SKIP_HALF;
    else if (op_signed ? (opa[31:23] == {9{opa[23]}}) : (opa[31:24] == 8'h00))
      skip = muldiv_pkg::SKIP_TRIPLE;
    else
      skip = muldiv_pkg::CNT_ZERO;
    shifted = {rem_q, quo_q[31]};
    trial   = {1'b0, shifted} - {2'b00, dvs_q};
    unique case (st_q)
      muldiv_pkg::S_IDLE:
      begin
        if (accept && is_div)
        begin
          st_d   = muldiv_pkg::S_DIV;
          cnt_d  = 6'(muldiv_pkg::DIV_STEPS - skip);
          quo_d  = mag_a << skip;
          rem_d  = muldiv_pkg::WORD_ZERO;
          dvs_d  = mag_b;
          qneg_d = op_signed && (opa[31] ^ opb[31]);
          rneg_d = op_signed && opa[31];
        end
      end
      muldiv_pkg::S_DIV:
      begin
        // restoring step: one quotient bit per clock
        quo_d = {quo_q[30:0], !trial[33]};
        rem_d = trial[33] ? shifted[31:0] : trial[31:0];
        cnt_d = 6'(cnt_q - 6'h01);
        if (cnt_q == 6'h01)
          st_d = muldiv_pkg::S_FIX;
      end
      muldiv_pkg::S_FIX:
      begin
        st_d   = muldiv_pkg::S_IDLE;
        done_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_q   <= muldiv_pkg::S_IDLE;
      cnt_q  <= muldiv_pkg::CNT_ZERO;
      quo_q  <= muldiv_pkg::WORD_ZERO;
      rem_q  <= muldiv_pkg::WORD_ZERO;
      dvs_q  <= muldiv_pkg::WORD_ZERO;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      quo_q  <= quo_d;
      rem_q  <= rem_d;
      dvs_q  <= dvs_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
    end
  end

  // result pair and issue interlock
  always_comb
  begin
    hilo_d = hilo_q;
    if (st_q == muldiv_pkg::S_FIX)
      hilo_d = {rneg_q ? 32'(-rem_q) : rem_q, qneg_q ? 32'(-quo_q) : quo_q};
    else if (pv_q)
      hilo_d = pacc_q ? 64'(hilo_q + pprod_q) : pprod_q;
    // stall covers the second pass slot and the whole divide
    stall_d = (st_d != muldiv_pkg::S_IDLE) || pass2_d;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      hilo_q  <= muldiv_pkg::HILO_RESET;
      stall_q <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      hilo_q  <= hilo_d;
      stall_q <= stall_d;
      done_q  <= done_d;
    end
  end

  assign result.result_high_reg = hilo_q[63:32];
  assign result.result_low_reg  = hilo_q[31:0];
  assign issue_stall            = stall_q;
  assign divide_done            = done_q;

  // checking
  logic [31:0]               cap_opa_q;
  logic [31:0]               cap_opb_q;
  logic                      cap_uns_q;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cap_opa_q <= muldiv_pkg::WORD_ZERO;
      cap_opb_q <= muldiv_pkg::WORD_ZERO;
      cap_uns_q <= 1'b0;
    end
    else if (accept && is_div)
    begin
      cap_opa_q <= opa;
      cap_opb_q <= opb;
      cap_uns_q <= (issue.op == muldiv_pkg::OP_DIVU);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_long_interlock;
    mul_long |=> issue_stall ##1 !issue_stall;
  endproperty
  a_long_interlock: assert property (p_long_interlock) else $error("full multiply interlock wrong");

  property p_short_rate;
    (accept && is_mul && opb_short && st_q == muldiv_pkg::S_IDLE) |=> !issue_stall;
  endproperty
  a_short_rate: assert property (p_short_rate) else $error("short multiply stalled issue");

  property p_short_product;
    (accept && issue.op == muldiv_pkg::OP_MULTU && opb[31:16] == 16'h0000)
      |-> ##2 hilo_q == $past(64'(opa) * 64'(opb), 2);
  endproperty
  a_short_product: assert property (p_short_product) else $error("one pass product wrong");

  property p_long_product;
    (accept && issue.op == muldiv_pkg::OP_MULTU && opb[31:16] != 16'h0000)
      |-> ##3 hilo_q == $past(64'(opa) * 64'(opb), 3);
  endproperty
  a_long_product: assert property (p_long_product) else $error("two pass product wrong");

  property p_div_stall;
    (accept && is_div) |=> issue_stall [*8];
  endproperty
  a_div_stall: assert property (p_div_stall) else $error("divide did not stall issue");

  property p_div_bound;
    (accept && is_div) |-> ##[11:34] divide_done;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("divide latency out of range");

  property p_byte_skip;
    (accept && issue.op == muldiv_pkg::OP_DIVU && opa[31:8] == 24'h00_0000) |-> ##11 divide_done;
  endproperty
  a_byte_skip: assert property (p_byte_skip) else $error("byte dividend skip wrong");

  property p_bit_step;
    (st_q == muldiv_pkg::S_DIV && cnt_q > 6'h01) |=> cnt_q == 6'($past(cnt_q) - 6'h01);
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("divider step count wrong");

  property p_div_result;
    (divide_done && cap_uns_q && cap_opb_q != 32'h0000_0000)
      |-> (64'(hilo_q[31:0]) * 64'(cap_opb_q) + 64'(hilo_q[63:32]) == 64'(cap_opa_q))
          && (hilo_q[63:32] < cap_opb_q);
  endproperty
  a_div_result: assert property (p_div_result) else $error("quotient or remainder wrong");

  property p_div_done_stall;
    divide_done |-> !issue_stall && $past(issue_stall);
  endproperty
  a_div_done_stall: assert property (p_div_done_stall) else $error("stall not released at end");

endmodule : mult_div_unit

// ### int_pipe_model.sv
// integer pipeline stand-in that issues queued operations to the unit
`timescale 1ns/100ps

module int_pipe_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       issue_stall,
  output logic            issue_valid,
  output muldiv_pkg::issue_s issue
);
  muldiv_pkg::issue_s pend[$];

  initial
  begin
    issue_valid = 1'b0;
    issue       = '0;
  end

  task automatic push(input muldiv_pkg::issue_s op);
    pend.push_back(op);
  endtask : push

  always @(posedge clock)
  begin
    if (!resetn)
      issue_valid <= 1'b0;
    else if (!(issue_valid && issue_stall))
    begin
      if (pend.size() > 0)
      begin
        issue_valid <= 1'b1;
        issue       <= pend.pop_front();
      end
      else
      begin
        issue_valid <= 1'b0;
        // released lines must not look like a held request
        if (issue_valid)
          issue <= muldiv_pkg::issue_s'(~issue);
      end
    end
  end
endmodule : int_pipe_model

// ### tb_mult_div_unit.sv
// self-checking bench of the multiply/divide unit
`timescale 1ns/100ps

module tb_mult_div_unit;
  logic              clock = 1'b0;
  logic              resetn;
  logic              issue_valid;
  muldiv_pkg::issue_s  issue;
  muldiv_pkg::result_s result;
  logic              issue_stall;
  logic              divide_done;
  int                cycle = 0;
  int                mismatches = 0;
  int                check_count = 0;
  int                takes[$];
  int                dones[$];

  always #2.5 clock = ~clock;

  mult_div_unit uut (
    .clock       (clock),
    .resetn      (resetn),
    .issue_valid (issue_valid),
    .issue       (issue),
    .result      (result),
    .issue_stall (issue_stall),
    .divide_done (divide_done)
  );

  int_pipe_model model (
    .clock       (clock),
    .resetn      (resetn),
    .issue_stall (issue_stall),
    .issue_valid (issue_valid),
    .issue       (issue)
  );

  // edge numbers of every take and every divide completion
  always @(posedge clock)
  begin
    cycle <= cycle + 1;
    if (resetn && issue_valid === 1'b1 && issue_stall === 1'b0)
      takes.push_back(cycle);
    if (divide_done === 1'b1)
      dones.push_back(cycle);
    if (cycle == 6000)
    begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  function automatic logic [63:0] umul(input logic [31:0] a, input logic [31:0] b);
    return {32'h0000_0000, a} * {32'h0000_0000, b};
  endfunction : umul

  function automatic logic [63:0] smul(input logic [31:0] a, input logic [31:0] b);
    return $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
  endfunction : smul

  task automatic check_pair(input muldiv_pkg::result_s got, input logic [63:0] exp);
    check_count++;
    if (got !== muldiv_pkg::result_s'(exp))
    begin
      mismatches++;
      $display("[FAIL] %0t pair %h expected %h", $time, got, exp);
    end
  endtask : check_pair

  task automatic check_num(input int got, input int exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : check_num

  task automatic send(input muldiv_pkg::muldiv_op_e op, input logic [31:0] a,
                      input logic [31:0] b);
    model.push('{op, a, b});
  endtask : send

  // wait for the queue to drain and the unit to go quiet
  task automatic settle();
    int n;
    n = 0;
    @(negedge clock);
    while ((model.pend.size() != 0 || issue_valid || issue_stall) && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
  endtask : settle

  task automatic begin_case();
    @(negedge clock);
    takes.delete();
    dones.delete();
  endtask : begin_case

  task automatic short_burst();
    begin_case();
    send(muldiv_pkg::OP_MULTU, 32'hFFFF_1234, 32'h0000_7FFF);
    send(muldiv_pkg::OP_MULTU, 32'hFFFF_FFFF, 32'h0000_0003);
    send(muldiv_pkg::OP_MULT, 32'h8000_0000, 32'hFFFF_FFFE);
    settle();
    check_num(takes[1] - takes[0], 1);
    check_num(takes[2] - takes[0], 2);
    check_pair(result, smul(32'h8000_0000, 32'hFFFF_FFFE));
  endtask : short_burst

  task automatic full_pair();
    begin_case();
    send(muldiv_pkg::OP_MULTU, 32'hCAFE_0001, 32'h1234_5678);
    send(muldiv_pkg::OP_MULTU, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    send(muldiv_pkg::OP_MULT, 32'h8765_4321, 32'h8765_4321);
    settle();
    check_num(takes[1] - takes[0], 2);
    check_num(takes[2] - takes[1], 2);
    check_pair(result, smul(32'h8765_4321, 32'h8765_4321));
  endtask : full_pair

  task automatic accumulate();
    logic [63:0] exp;
    begin_case();
    send(muldiv_pkg::OP_MULTU, 32'hFFFF_FFFF, 32'h0001_0000);
    send(muldiv_pkg::OP_MADDU, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    send(muldiv_pkg::OP_MADD, 32'hFFFF_FFFF, 32'h0000_0005);
    exp = umul(32'hFFFF_FFFF, 32'h0001_0000) + umul(32'hFFFF_FFFF, 32'hFFFF_FFFF);
    exp = exp + smul(32'hFFFF_FFFF, 32'h0000_0005);
    settle();
    check_pair(result, exp);
  endtask : accumulate

  task automatic divide_table();
    logic [31:0] dvd[4] = '{32'h0000_00C8, 32'h0000_BEEF, 32'h00AB_CDEF, 32'hDEAD_BEEF};
    int lat[4] = '{11, 19, 27, 34};
    for (int i = 0; i < 4; i++)
    begin
      begin_case();
      send(muldiv_pkg::OP_DIVU, dvd[i], 32'h0000_0007);
      settle();
      check_num(dones[0] - takes[0], lat[i]);
      check_pair(result, {dvd[i] % 32'h7, dvd[i] / 32'h7});
    end
    begin_case();
    send(muldiv_pkg::OP_DIV, 32'hFFFF_FF9C, 32'h0000_0007);
    settle();
    check_num(dones[0] - takes[0], 11);
    check_pair(result, 64'hFFFF_FFFE_FFFF_FFF2);
  endtask : divide_table

  task automatic divide_stall();
    begin_case();
    send(muldiv_pkg::OP_DIVU, 32'h0000_1000, 32'h0000_0003);
    send(muldiv_pkg::OP_MULTU, 32'h0000_0005, 32'h0000_0006);
    settle();
    check_num(takes[1], dones[0]);
    check_pair(result, 64'h0000_0000_0000_001E);
  endtask : divide_stall

  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  initial
  begin
    resetn = 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    check_pair(result, 64'h0000_0000_0000_0000);
    short_burst();
    full_pair();
    accumulate();
    divide_table();
    divide_stall();
    report_and_stop();
  end
endmodule : tb_mult_div_unit
